// [core/psi_pkg.sv]
// Holds the register map, field layout, reset values and carrier types
// of the PLL status and interrupt unit.
// Assumes one core clock at 40 MHz and an APB master with 32-bit data.
//
// Notes on behaviour
// - Synth lock enable set lets a latched synth loss of lock pull the irq low.
// - VCXO lock enable set lets a latched VCXO loss of lock pull the irq low.
// - Each input loss-of-signal enable gates its own latched event onto the irq.
// - Reference enable set lets a latched reference loss pull the irq low.
// - Holdover enable set lets a latched holdover entry pull the irq low.
// - Synth lock latch reads 0 after any loss since clear; write 1 clears.
// - VCXO lock latch reads 0 after any loss since clear; write 1 clears.
// - Each input signal latch reads 0 after any loss; write 1 clears.
// - Reference latch reads 0 if reference lost since clear; write 1 clears.
// - Holdover latch reads 0 after any holdover entry; write 1 clears.
// - Live synth lock bit reads 0 on loss of lock, feeds its latch.
// - Live VCXO lock bit reads 0 on loss of lock, feeds its latch.
// - Live input signal bits read 0 on loss of signal, feed latches.
// - Live reference bit reads 1 while selected input has a reference.
// - Live holdover bit reads 0 while the VCXO loop is in holdover.
// - Selection bit shows chosen input: 0 first clock, 1 second.
// - Calibration bit reads 1 while synth calibration runs, else 0.

package psi_pkg;

	// Register indices as printed; byte address is four times the index
	localparam logic [7:0]  ENABLE_IDX  = 8'h4c;
	localparam logic [7:0]  STICKY_IDX  = 8'h50;
	localparam logic [7:0]  LIVE_IDX    = 8'h51;
	localparam logic [7:0]  CAL_IDX     = 8'h53;
	localparam logic [11:0] ENABLE_ADDR = {2'b00, ENABLE_IDX, 2'b00};
	localparam logic [11:0] STICKY_ADDR = {2'b00, STICKY_IDX, 2'b00};
	localparam logic [11:0] LIVE_ADDR   = {2'b00, LIVE_IDX, 2'b00};
	localparam logic [11:0] CAL_ADDR    = {2'b00, CAL_IDX, 2'b00};

	// Field layout
	localparam int FLAGS_W = 6;
	localparam int SEL_BIT = 6;
	localparam int CAL_BIT = 2;

	// One bit per condition, in register bit order 5 down to 0
	typedef struct packed {
		logic       synth;
		logic       vcxo;
		logic       reference;
		logic       hold;
		logic [1:0] clk;
	} psi_flags_s;

	// Raw status arriving from the PLL and input monitors
	typedef struct packed {
		logic       sel;
		logic       cal;
		psi_flags_s live;
	} psi_raw_s;

	// Values after reset
	localparam psi_flags_s ENABLE_RST = 6'h00;
	localparam psi_flags_s EVENT_RST  = 6'h00;
	localparam psi_raw_s   RAW_RST    = 8'h3f;
	localparam logic       IRQ_RST    = 1'b1;

endpackage

// [core/psi_unit.sv]
// PLL status and interrupt unit: live status, sticky event latches,
// interrupt enables and an active-low interrupt request, on APB.
// Latches hold 1 for an event inside so that reset clears them with a
// constant; software reads the inverted sense, 0 meaning an event.
// Assumes raw status inputs are asynchronous to ref_clk and that the
// APB master follows the usual setup and access phases.
//
// Added by the designer: the APB interface to the registers and the register offsets.

`timescale 1ns/1ps

module psi_unit
	import psi_pkg::*;
(
	input  wire logic        ref_clk,               // Core clock, 40 MHz
	input  wire logic        rst_n,                 // Async reset, active low
	input  wire logic        psel,                  // APB select
	input  wire logic        penable,               // APB access phase
	input  wire logic        pwrite,                // APB direction, 1 = write
	input  wire logic [11:0] paddr,                 // APB byte address
	input  wire logic [31:0] pwdata,                // APB write data
	input  wire logic [3:0]  pstrb,                 // APB write strobes
	output logic      [31:0] prdata,                // APB read data
	output logic             pready,                // APB ready
	output logic             pslverr,               // APB error, unmapped address
	input  wire psi_raw_s    raw_in,                // Raw status from PLL logic
	output logic             interrupt_request_low  // Interrupt, active low
);

	////////////////////////////////////////////////////////////////////////
	// Synchronisers

	psi_raw_s   sync1;
	psi_raw_s   sync2;
	psi_flags_s bad;

	// Raw levels come from other clock domains; a single stage could hand
	// a metastable value to the latches and fake an event
	// Two stages; the first is read only by the second
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1 <= RAW_RST;
			sync2 <= RAW_RST;
		end else begin
			sync1 <= raw_in;
			sync2 <= sync1;
		end
	end

	// A live 0 means a fault in every flag
	assign bad = ~sync2.live;

	////////////////////////////////////////////////////////////////////////
	// APB decode

	logic setup;
	logic access;
	logic hit_en;
	logic hit_stk;
	logic hit_live;
	logic hit_cal;
	logic mapped;
	logic wr_lane0;

	assign setup    = psel & ~penable;
	assign access   = psel & penable;
	assign hit_en   = (paddr == ENABLE_ADDR);
	assign hit_stk  = (paddr == STICKY_ADDR);
	assign hit_live = (paddr == LIVE_ADDR);
	assign hit_cal  = (paddr == CAL_ADDR);
	assign mapped   = hit_en | hit_stk | hit_live | hit_cal;

	// All fields live in byte lane 0; a write without it changes nothing
	assign wr_lane0 = access & pwrite & pstrb[0];

	// Zero wait states: every access phase completes at once
	assign pready = access;

	////////////////////////////////////////////////////////////////////////
	// Interrupt enables

	psi_flags_s enables;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			enables <= ENABLE_RST;
		end else if (wr_lane0 && hit_en) begin
			enables <= psi_flags_s'(pwdata[FLAGS_W-1:0]);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sticky event latches, held as 1 = event seen; read back inverted

	psi_flags_s events;
	psi_flags_s clr;
	psi_flags_s next_events;

	// Set beats clear, so a fault that is present while software clears
	// cannot slip through unseen
	// Write 1 clears; a fault present in the same cycle sets again
	always_comb begin
		clr = EVENT_RST;
		if (wr_lane0 && hit_stk) begin
			clr = psi_flags_s'(pwdata[FLAGS_W-1:0]);
		end
		next_events = (events & ~clr) | bad;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			events <= EVENT_RST;
		end else begin
			events <= next_events;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Interrupt request

	logic pending;
	logic next_irq_low;

	// The extra cycle is small next to the synchroniser delay
	// Registered so the pin never glitches on a decode hazard
	assign pending      = |(events & enables);
	assign next_irq_low = ~pending;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			interrupt_request_low <= IRQ_RST;
		end else begin
			interrupt_request_low <= next_irq_low;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read data, captured in the setup cycle

	logic [31:0] next_rdata;

	always_comb begin
		next_rdata = 32'h0;
		if (hit_en) begin
			next_rdata[FLAGS_W-1:0] = enables;
		end
		if (hit_stk) begin
			next_rdata[FLAGS_W-1:0] = ~events;
		end
		if (hit_live) begin
			next_rdata[FLAGS_W-1:0] = sync2.live;
			next_rdata[SEL_BIT]     = sync2.sel;
		end
		if (hit_cal) begin
			next_rdata[CAL_BIT] = sync2.cal;
		end
	end

	// Captured at setup so that the access phase, with pready high at
	// once, already sees settled data
	// Data and error stand from setup through the access phase
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata  <= 32'h0;
			pslverr <= 1'b0;
		end else if (setup) begin
			prdata  <= pwrite ? 32'h0 : next_rdata;
			pslverr <= ~mapped;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks

	a_synth_irq_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
		events.synth && enables.synth |=> !interrupt_request_low)
		else $error("synth lock event enabled but irq not low");

	a_vcxo_irq_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
		events.vcxo && enables.vcxo |=> !interrupt_request_low)
		else $error("vcxo lock event enabled but irq not low");

	a_clk_irq_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
		|(events.clk & enables.clk) |=> !interrupt_request_low)
		else $error("input los event enabled but irq not low");

	a_ref_irq_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
		events.reference && enables.reference |=> !interrupt_request_low)
		else $error("reference event enabled but irq not low");

	a_hold_irq_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
		events.hold && enables.hold |=> !interrupt_request_low)
		else $error("holdover event enabled but irq not low");

	a_irq_release: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(events & enables) == EVENT_RST |=> interrupt_request_low)
		else $error("irq low with nothing enabled pending");

	a_fault_sets_latch: assert property (@(posedge ref_clk) disable iff (!rst_n)
		bad != EVENT_RST |=> (events & $past(bad)) == $past(bad))
		else $error("live fault did not set its latch");

	a_synth_w1c: assert property (@(posedge ref_clk) disable iff (!rst_n)
		wr_lane0 && hit_stk && pwdata[5] && !bad.synth |=> !events.synth)
		else $error("synth latch not cleared by write one");

	a_vcxo_w1c: assert property (@(posedge ref_clk) disable iff (!rst_n)
		wr_lane0 && hit_stk && pwdata[4] && !bad.vcxo |=> !events.vcxo)
		else $error("vcxo latch not cleared by write one");

	a_clk0_w1c: assert property (@(posedge ref_clk) disable iff (!rst_n)
		wr_lane0 && hit_stk && pwdata[0] && !bad.clk[0] |=> !events.clk[0])
		else $error("input latch not cleared by write one");

	a_ref_w1c: assert property (@(posedge ref_clk) disable iff (!rst_n)
		wr_lane0 && hit_stk && pwdata[3] && !bad.reference |=> !events.reference)
		else $error("reference latch not cleared by write one");

	a_hold_w1c: assert property (@(posedge ref_clk) disable iff (!rst_n)
		wr_lane0 && hit_stk && pwdata[2] && !bad.hold |=> !events.hold)
		else $error("holdover latch not cleared by write one");

	a_live_readback: assert property (@(posedge ref_clk) disable iff (!rst_n)
		setup && !pwrite && hit_live
		|=> prdata[SEL_BIT:0] == {$past(sync2.sel), $past(sync2.live)})
		else $error("live status read mismatch");

	a_cal_readback: assert property (@(posedge ref_clk) disable iff (!rst_n)
		setup && !pwrite && hit_cal |=> prdata[CAL_BIT] == $past(sync2.cal))
		else $error("calibration status read mismatch");

	a_sticky_readback: assert property (@(posedge ref_clk) disable iff (!rst_n)
		setup && !pwrite && hit_stk |=> prdata[FLAGS_W-1:0] == ~$past(events))
		else $error("sticky read is not inverted latch state");

	////////////////////////////////////////////////////////////////////////
	// Interrupt masking and cause
	// A pending event with its enable clear, and no enabled event pending, must leave the pin high

	a_synth_irq_mask: assert property (@(posedge ref_clk) disable iff (!rst_n)
		events.synth && !enables.synth && (events & enables) == EVENT_RST
		|=> interrupt_request_low)
		else $error("masked synth event drove irq");

	a_vcxo_irq_mask: assert property (@(posedge ref_clk) disable iff (!rst_n)
		events.vcxo && !enables.vcxo && (events & enables) == EVENT_RST
		|=> interrupt_request_low)
		else $error("masked vcxo event drove irq");

	a_clk_irq_mask: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(events.clk & ~enables.clk) != 2'h0 && (events & enables) == EVENT_RST
		|=> interrupt_request_low)
		else $error("masked input los event drove irq");

	a_ref_irq_mask: assert property (@(posedge ref_clk) disable iff (!rst_n)
		events.reference && !enables.reference && (events & enables) == EVENT_RST
		|=> interrupt_request_low)
		else $error("masked reference event drove irq");

	a_hold_irq_mask: assert property (@(posedge ref_clk) disable iff (!rst_n)
		events.hold && !enables.hold && (events & enables) == EVENT_RST
		|=> interrupt_request_low)
		else $error("masked holdover event drove irq");

	a_idle_irq_high: assert property (@(posedge ref_clk) disable iff (!rst_n)
		enables == ENABLE_RST
		|=> interrupt_request_low)
		else $error("irq low with every enable clear");

	a_irq_has_cause: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!interrupt_request_low
		|-> $past((events & enables) != EVENT_RST))
		else $error("irq low without an enabled pending event");

	a_irq_steady: assert property (@(posedge ref_clk) disable iff (!rst_n)
		$stable(events & enables)
		|=> $stable(interrupt_request_low))
		else $error("irq moved with no change in pending events");

	////////////////////////////////////////////////////////////////////////
	// Latch behaviour
	// Only a live fault sets a latch and only a write of 1 clears it

	a_clk1_w1c: assert property (@(posedge ref_clk) disable iff (!rst_n)
		wr_lane0 && hit_stk && pwdata[1] && !bad.clk[1]
		|=> !events.clk[1])
		else $error("second input latch not cleared by write one");

	a_latch_keeps: assert property (@(posedge ref_clk) disable iff (!rst_n)
		events != EVENT_RST && !(wr_lane0 && hit_stk)
		|=> (events & $past(events)) == $past(events))
		else $error("latch lost an event without a clear");

	a_clear_others: assert property (@(posedge ref_clk) disable iff (!rst_n)
		wr_lane0 && hit_stk
		|=> (events & $past(events & ~clr)) == $past(events & ~clr))
		else $error("clear write dropped a latch written as zero");

	a_no_false_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
		bad == EVENT_RST
		|=> (events & ~$past(events)) == EVENT_RST)
		else $error("latch set with no live fault");

	a_read_keeps: assert property (@(posedge ref_clk) disable iff (!rst_n)
		setup && !pwrite && hit_stk && bad == EVENT_RST
		|=> events == $past(events))
		else $error("sticky read changed the latches");

	a_ro_write_keeps: assert property (@(posedge ref_clk) disable iff (!rst_n)
		wr_lane0 && (hit_live || hit_cal) && bad == EVENT_RST
		|=> events == $past(events) && $stable(enables))
		else $error("write to read-only status changed state");

	a_lane_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
		access && pwrite && !pstrb[0] && bad == EVENT_RST
		|=> events == $past(events) && $stable(enables))
		else $error("write without lane 0 changed state");

	////////////////////////////////////////////////////////////////////////
	// Enable register
	// Plain read and write storage, touched only by its own address

	a_enable_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
		wr_lane0 && hit_en
		|=> enables == psi_flags_s'($past(pwdata[FLAGS_W-1:0])))
		else $error("enable write did not land");

	a_enable_keeps: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!(wr_lane0 && hit_en)
		|=> $stable(enables))
		else $error("enables changed without a write");

	a_enable_readback: assert property (@(posedge ref_clk) disable iff (!rst_n)
		setup && !pwrite && hit_en
		|=> prdata[FLAGS_W-1:0] == $past(enables))
		else $error("enable read mismatch");

	////////////////////////////////////////////////////////////////////////
	// Bus response
	// Read data and error are set at setup and stand until the next one

	a_reserved_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
		setup && !pwrite
		|=> prdata[31:7] == 25'h0)
		else $error("reserved read bits not zero");

	a_cal_only_bit: assert property (@(posedge ref_clk) disable iff (!rst_n)
		setup && !pwrite && hit_cal
		|=> (prdata & ~(32'h1 << CAL_BIT)) == 32'h0)
		else $error("calibration read shows other bits");

	a_write_reads_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
		setup && pwrite
		|=> prdata == 32'h0)
		else $error("read data not zero during a write");

	a_unmapped_error: assert property (@(posedge ref_clk) disable iff (!rst_n)
		setup && !mapped
		|=> pslverr && prdata == 32'h0)
		else $error("unmapped address not refused");

	a_mapped_no_error: assert property (@(posedge ref_clk) disable iff (!rst_n)
		setup && mapped
		|=> !pslverr)
		else $error("mapped address flagged as error");

	a_rdata_holds: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!setup
		|=> $stable(prdata) && $stable(pslverr))
		else $error("read data or error moved outside setup");

	a_ready_in_access: assert property (@(posedge ref_clk) disable iff (!rst_n)
		psel && penable
		|-> pready)
		else $error("access phase without ready");

	a_ready_only_access: assert property (@(posedge ref_clk) disable iff (!rst_n)
		pready
		|-> psel && penable)
		else $error("ready outside an access phase");

endmodule // psi_unit

// [dv/psi_unit_tb.sv]
// Self-checking bench for the PLL status and interrupt unit.
// Assumes a 40 MHz core clock and the APB map and timing of psi_pkg.
`timescale 1ns/1ps

module psi_unit_tb
	import psi_pkg::*;
;
	logic        ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, irq_low;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0]  pstrb;
	psi_raw_s    raw_in;
	int          num_errors, total_checks;

	psi_unit psi_unit_inst (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .raw_in(raw_in), .interrupt_request_low(irq_low));

	// Free-running core clock, 25 ns period
	always #12.5 ref_clk = ~ref_clk;

	////////////////////////////////////////////////////////////////////////////////
	// Checking and bus tasks
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string m);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	task automatic chk_bit(input logic got, input logic exp, input string m);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %0t %s got %b", $time, m, got);
		end
	endtask

	// One transfer; waits on pready, never on a fixed count
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge ref_clk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// Settle past the update edges before sampling
	task automatic settle(input int n);
		repeat (n) @(negedge ref_clk);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic reset_values();
		logic [31:0] r;
		logic        e;
		apb(1'b0, ENABLE_ADDR, 32'h0, r, e);
		chk_word(r, 32'h0, "enable reset");
		chk_bit(e, 1'b0, "mapped no error");
		apb(1'b0, STICKY_ADDR, 32'h0, r, e);
		chk_word(r, 32'h3f, "sticky reset");
		apb(1'b0, 12'hffc, 32'h0, r, e);
		chk_bit(e, 1'b1, "unmapped error");
		// A write without byte lane 0 must leave the enables alone
		pstrb <= 4'he;
		apb(1'b1, ENABLE_ADDR, 32'h3f, r, e);
		pstrb <= 4'hf;
		apb(1'b0, ENABLE_ADDR, 32'h0, r, e);
		chk_word(r, 32'h0, "write without lane 0");
		chk_bit(irq_low, 1'b1, "irq idle");
	endtask

	// Fault on one source, mask it, unmask it, clear it
	task automatic one_source(input int i);
		logic [5:0]  m;
		logic [31:0] r;
		logic        e;
		m = 6'h01 << i;
		apb(1'b1, ENABLE_ADDR, {26'h0, m}, r, e);
		apb(1'b0, ENABLE_ADDR, 32'h0, r, e);
		chk_word(r, {26'h0, m}, "enable readback");
		raw_in.live <= 6'h3f & ~m;
		settle(5);
		apb(1'b0, LIVE_ADDR, 32'h0, r, e);
		chk_word(r, {26'h0, 6'h3f & ~m}, "live");
		raw_in.live <= 6'h3f;
		settle(5);
		apb(1'b0, STICKY_ADDR, 32'h0, r, e);
		chk_word(r, {26'h0, 6'h3f & ~m}, "sticky");
		chk_bit(irq_low, 1'b0, "irq on");
		apb(1'b1, ENABLE_ADDR, 32'h0, r, e);
		settle(2);
		chk_bit(irq_low, 1'b1, "irq masked");
		apb(1'b1, ENABLE_ADDR, {26'h0, m}, r, e);
		settle(2);
		chk_bit(irq_low, 1'b0, "irq unmasked");
		apb(1'b1, STICKY_ADDR, {26'h0, m}, r, e);
		settle(2);
		chk_bit(irq_low, 1'b1, "irq cleared");
		apb(1'b0, STICKY_ADDR, 32'h0, r, e);
		chk_word(r, 32'h3f, "sticky cleared");
		apb(1'b1, ENABLE_ADDR, 32'h0, r, e);
	endtask

	// A one-cycle fault reaches the latch three edges later, at the very
	// edge on which the clear write lands; the event must survive it
	task automatic set_beats_clear();
		logic [31:0] r;
		logic        e;
		@(posedge ref_clk);
		raw_in.live <= 6'h3e;
		fork
			apb(1'b1, STICKY_ADDR, 32'h1, r, e);
			begin
				@(posedge ref_clk);
				raw_in.live <= 6'h3f;
			end
		join
		apb(1'b0, STICKY_ADDR, 32'h0, r, e);
		chk_word(r, 32'h3e, "set over clear");
		apb(1'b1, STICKY_ADDR, 32'h1, r, e);
		apb(1'b0, STICKY_ADDR, 32'h0, r, e);
		chk_word(r, 32'h3f, "late clear");
	endtask

	task automatic select_and_cal();
		logic [31:0] r;
		logic        e;
		raw_in <= {1'b1, 1'b1, 6'h3f};
		settle(4);
		apb(1'b1, LIVE_ADDR, 32'h0, r, e);
		apb(1'b0, LIVE_ADDR, 32'h0, r, e);
		chk_word(r, 32'h7f, "select");
		apb(1'b0, CAL_ADDR, 32'h0, r, e);
		chk_word(r, 32'h4, "cal on");
		raw_in <= RAW_RST;
		settle(4);
		apb(1'b0, CAL_ADDR, 32'h0, r, e);
		chk_word(r, 32'h0, "cal done");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Verdict, watchdog and main sequence
	task automatic report_and_stop();
		if (num_errors == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// About 280 cycles are needed; the limit leaves ample margin
	initial begin
		repeat (20000) @(posedge ref_clk);
		num_errors++;
		report_and_stop();
	end

	initial begin
		ref_clk = 1'b0;
		rst_n = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		pstrb = 4'hf;
		raw_in = RAW_RST;
		num_errors = 0;
		total_checks = 0;
		repeat (8) @(posedge ref_clk);
		rst_n <= 1'b1;
		reset_values();
		for (int i = 0; i < FLAGS_W; i++)
			one_source(i);
		set_beats_clear();
		select_and_cal();
		report_and_stop();
	end
endmodule // psi_unit_tb
